// ### core/csb_byte_reg.v
// One special function byte register with byte, bit and hardware loads
`default_nettype none

module csb_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] WMASK   = 8'hFF
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       byte_we,
  input  wire [7:0] byte_data,
  input  wire       bit_we,
  input  wire [2:0] bit_idx,
  input  wire       bit_val,
  input  wire       hw_we,
  input  wire [7:0] hw_data,
  output wire [7:0] q
);

  reg [7:0] val_q;
  reg [7:0] val_d;

  always @* begin
    val_d = val_q;
    if (hw_we) begin
      val_d = hw_data;
    end else if (byte_we) begin
      val_d = byte_data;
    end else if (bit_we) begin
      val_d[bit_idx] = bit_val;
    end
    // Masked bits hold their reset value
    val_d = (val_d & WMASK) | (RST_VAL & ~WMASK);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign q = val_q;

endmodule // csb_byte_reg

`default_nettype wire

// ### core/csb_core_status.v
// Core status special function registers of an 8051-class CPU
`default_nettype none
`include "csb_consts.vh"

module csb_core_status (
  input  wire        clk,
  input  wire        rst_b,
  // Direct byte access from the CPU
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_rd,
  output wire [7:0]  sfr_rdata,
  output wire        sfr_hit,
  // Single-bit access, bit address 80H..FFH
  input  wire [7:0]  sfr_bit_addr,
  input  wire        sfr_bit_wr,
  input  wire        sfr_bit_val,
  // Arithmetic results
  input  wire        acc_load,
  input  wire [7:0]  acc_data,
  input  wire        muldiv_load,
  input  wire [7:0]  muldiv_acc,
  input  wire [7:0]  muldiv_helper,
  input  wire        flags_load,
  input  wire        carry_in,
  input  wire        half_carry_in,
  input  wire        signed_wrap_in,
  // Memory pointer as one word
  input  wire        mem_ptr_load,
  input  wire [15:0] mem_ptr_data,
  // Stack operations
  input  wire        stack_push,
  input  wire [7:0]  push_data,
  input  wire        stack_pop,
  output wire        ram_wr,
  output wire [7:0]  ram_waddr,
  output wire [7:0]  ram_wdata,
  // Working register lookup
  input  wire [2:0]  work_reg_idx,
  output wire [7:0]  work_reg_addr,
  // Serial control read-back
  input  wire        ss_pin,
  input  wire [7:0]  spi_ctrl_in,
  input  wire        serial_master_sel,
  output wire [7:0]  spi_ctrl_view,
  // Register contents
  output wire [7:0]  accumulator,
  output wire [7:0]  multiply_helper,
  output wire [7:0]  stack_pointer,
  output wire [15:0] memory_pointer,
  output wire [7:0]  cpu_status_word,
  output wire [1:0]  bank_sel,
  output wire        baud_doubler,
  output wire        serial_wake_irq_en,
  output wire        ext0_wake_irq_en,
  output wire        power_down_en,
  output wire        cpu_doze_en
);

  wire [7:0] acc_q;
  wire [7:0] helper_q;
  wire [7:0] dpl_q;
  wire [7:0] dph_q;
  wire [7:0] pctl_q;
  reg  [7:0] sp_q;
  reg  [7:0] sp_d;
  reg  [7:0] sw_q;
  reg  [7:0] sw_d;
  reg        ram_wr_q;
  reg  [7:0] ram_waddr_q;
  reg  [7:0] ram_wdata_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg        hit_q;
  reg        hit_d;
  reg        ss_meta_q;
  reg        ss_sync_q;

  wire       parity_bit;
  wire [7:0] bit_byte_addr;
  wire       bit_ok;
  wire [2:0] bit_idx;
  wire       bw_acc;
  wire       bw_helper;
  wire       bw_sw;

  // Byte write strobes
  wire we_acc    = sfr_wr && (sfr_addr == `CSB_ADDR_ACCUMULATOR);
  wire we_helper = sfr_wr && (sfr_addr == `CSB_ADDR_MULT_HELPER);
  wire we_sw     = sfr_wr && (sfr_addr == `CSB_ADDR_CPU_STATUS);
  wire we_pctl   = sfr_wr && (sfr_addr == `CSB_ADDR_POWER_CONTROL);
  wire we_sp     = sfr_wr && (sfr_addr == `CSB_ADDR_STACK_POINTER);
  wire we_dpl    = sfr_wr && (sfr_addr == `CSB_ADDR_MEM_PTR_LOW);
  wire we_dph    = sfr_wr && (sfr_addr == `CSB_ADDR_MEM_PTR_HIGH);

  // Bit address selects a byte whose low three address bits are zero
  assign bit_byte_addr = {sfr_bit_addr[7:3], `CSB_BITADDR_LOW};
  assign bit_idx       = sfr_bit_addr[2:0];
  assign bit_ok        = sfr_bit_wr && sfr_bit_addr[`CSB_BIT_SFR_SPACE];
  assign bw_acc        = bit_ok && (bit_byte_addr == `CSB_ADDR_ACCUMULATOR);
  assign bw_helper     = bit_ok && (bit_byte_addr == `CSB_ADDR_MULT_HELPER);
  assign bw_sw         = bit_ok && (bit_byte_addr == `CSB_ADDR_CPU_STATUS);

  // Accumulator: arithmetic load wins over software write
  csb_byte_reg #(
    .RST_VAL (`CSB_RST_ACCUMULATOR),
    .WMASK   (`CSB_MASK_ALL)
  ) u_acc (
    .clk       (clk),
    .rst_b     (rst_b),
    .byte_we   (we_acc),
    .byte_data (sfr_wdata),
    .bit_we    (bw_acc),
    .bit_idx   (bit_idx),
    .bit_val   (sfr_bit_val),
    .hw_we     (acc_load | muldiv_load),
    .hw_data   (muldiv_load ? muldiv_acc : acc_data),
    .q         (acc_q)
  );

  // Helper byte: second operand and result of multiply/divide
  csb_byte_reg #(
    .RST_VAL (`CSB_RST_MULT_HELPER),
    .WMASK   (`CSB_MASK_ALL)
  ) u_helper (
    .clk       (clk),
    .rst_b     (rst_b),
    .byte_we   (we_helper),
    .byte_data (sfr_wdata),
    .bit_we    (bw_helper),
    .bit_idx   (bit_idx),
    .bit_val   (sfr_bit_val),
    .hw_we     (muldiv_load),
    .hw_data   (muldiv_helper),
    .q         (helper_q)
  );

  // Memory pointer bytes, loadable as one word
  csb_byte_reg #(
    .RST_VAL (`CSB_RST_MEM_PTR),
    .WMASK   (`CSB_MASK_ALL)
  ) u_dpl (
    .clk       (clk),
    .rst_b     (rst_b),
    .byte_we   (we_dpl),
    .byte_data (sfr_wdata),
    .bit_we    (1'b0),
    .bit_idx   (bit_idx),
    .bit_val   (sfr_bit_val),
    .hw_we     (mem_ptr_load),
    .hw_data   (mem_ptr_data[7:0]),
    .q         (dpl_q)
  );

  csb_byte_reg #(
    .RST_VAL (`CSB_RST_MEM_PTR),
    .WMASK   (`CSB_MASK_ALL)
  ) u_dph (
    .clk       (clk),
    .rst_b     (rst_b),
    .byte_we   (we_dph),
    .byte_data (sfr_wdata),
    .bit_we    (1'b0),
    .bit_idx   (bit_idx),
    .bit_val   (sfr_bit_val),
    .hw_we     (mem_ptr_load),
    .hw_data   (mem_ptr_data[15:8]),
    .q         (dph_q)
  );

  // Power control: byte access only, reserved bit held at zero
  csb_byte_reg #(
    .RST_VAL (`CSB_RST_POWER_CONTROL),
    .WMASK   (`CSB_MASK_POWER_CONTROL)
  ) u_pctl (
    .clk       (clk),
    .rst_b     (rst_b),
    .byte_we   (we_pctl),
    .byte_data (sfr_wdata),
    .bit_we    (1'b0),
    .bit_idx   (bit_idx),
    .bit_val   (sfr_bit_val),
    .hw_we     (1'b0),
    .hw_data   (`CSB_RST_POWER_CONTROL),
    .q         (pctl_q)
  );

  // Stack pointer
  always @* begin
    sp_d = sp_q;
    if (stack_push) begin
      sp_d = sp_q + 8'h01;
    end else if (stack_pop) begin
      sp_d = sp_q - 8'h01;
    end else if (we_sp) begin
      sp_d = sfr_wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q        <= `CSB_RST_STACK_POINTER;
      ram_wr_q    <= 1'b0;
      ram_waddr_q <= `CSB_RST_STACK_POINTER;
      ram_wdata_q <= `CSB_RST_RAM_DATA;
    end else begin
      sp_q        <= sp_d;
      ram_wr_q    <= stack_push;
      // Write lands at the already incremented pointer
      if (stack_push) begin
        ram_waddr_q <= sp_d;
        ram_wdata_q <= push_data;
      end
    end
  end

  // Status word, parity stored as zero and replaced by live value
  always @* begin
    sw_d = sw_q;
    if (we_sw) begin
      sw_d = sfr_wdata;
    end else if (bw_sw) begin
      sw_d[bit_idx] = sfr_bit_val;
    end
    if (flags_load) begin
      sw_d[`CSB_SW_CARRY]       = carry_in;
      sw_d[`CSB_SW_HALF_CARRY]  = half_carry_in;
      sw_d[`CSB_SW_SIGNED_WRAP] = signed_wrap_in;
    end
    sw_d[`CSB_SW_PARITY] = 1'b0;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_q <= `CSB_RST_CPU_STATUS;
    end else begin
      sw_q <= sw_d;
    end
  end

  assign parity_bit = ^acc_q;

  // Slave-select pin synchroniser
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_meta_q <= `CSB_RST_SS_SYNC;
      ss_sync_q <= `CSB_RST_SS_SYNC;
    end else begin
      ss_meta_q <= ss_pin;
      ss_sync_q <= ss_meta_q;
    end
  end

  assign spi_ctrl_view = {spi_ctrl_in[7:1],
                          serial_master_sel ? spi_ctrl_in[`CSB_SPI_RATE_BIT0]
                                            : ss_sync_q};

  // Registered read data
  always @* begin
    rdata_d = `CSB_UNMAPPED_RDATA;
    hit_d   = 1'b1;
    case (sfr_addr)
      `CSB_ADDR_ACCUMULATOR:   rdata_d = acc_q;
      `CSB_ADDR_MULT_HELPER:   rdata_d = helper_q;
      `CSB_ADDR_CPU_STATUS:    rdata_d = cpu_status_word;
      `CSB_ADDR_POWER_CONTROL: rdata_d = pctl_q;
      `CSB_ADDR_STACK_POINTER: rdata_d = sp_q;
      `CSB_ADDR_MEM_PTR_LOW:   rdata_d = dpl_q;
      `CSB_ADDR_MEM_PTR_HIGH:  rdata_d = dph_q;
      default:                 hit_d   = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `CSB_RST_RDATA;
      hit_q   <= 1'b0;
    end else if (sfr_rd) begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_hit   = hit_q;

  assign ram_wr    = ram_wr_q;
  assign ram_waddr = ram_waddr_q;
  assign ram_wdata = ram_wdata_q;

  assign cpu_status_word = {sw_q[7:1], parity_bit};
  assign bank_sel        = {sw_q[`CSB_SW_BANK_HIGH], sw_q[`CSB_SW_BANK_LOW]};
  // Bank base is eight times the bank number
  assign work_reg_addr   = {3'h0, bank_sel, work_reg_idx};

  assign accumulator     = acc_q;
  assign multiply_helper = helper_q;
  assign stack_pointer   = sp_q;
  assign memory_pointer  = {dph_q, dpl_q};

  assign baud_doubler       = pctl_q[`CSB_PC_BAUD_DOUBLER];
  assign serial_wake_irq_en = pctl_q[`CSB_PC_SERIAL_WAKE];
  assign ext0_wake_irq_en   = pctl_q[`CSB_PC_EXT0_WAKE];
  assign power_down_en      = pctl_q[`CSB_PC_POWER_DOWN];
  assign cpu_doze_en        = pctl_q[`CSB_PC_DOZE];

endmodule // csb_core_status

`default_nettype wire

// ### shared/csb_consts.vh
// Constants for the core status register bank
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH

// Direct addresses of the special function registers
`define CSB_ADDR_POWER_CONTROL   8'h87
`define CSB_ADDR_CPU_STATUS      8'hD0
`define CSB_ADDR_ACCUMULATOR     8'hE0
`define CSB_ADDR_MULT_HELPER     8'hF0
`define CSB_ADDR_STACK_POINTER   8'h81
`define CSB_ADDR_MEM_PTR_LOW     8'h82
`define CSB_ADDR_MEM_PTR_HIGH    8'h83

// Reset values
`define CSB_RST_POWER_CONTROL    8'h00
`define CSB_RST_CPU_STATUS       8'h00
`define CSB_RST_ACCUMULATOR      8'h00
`define CSB_RST_MULT_HELPER      8'h00
`define CSB_RST_STACK_POINTER    8'h07
`define CSB_RST_MEM_PTR          8'h00
`define CSB_RST_RDATA            8'h00
`define CSB_RST_RAM_DATA         8'h00
// Slave-select idles high, so the synchroniser starts there
`define CSB_RST_SS_SYNC          1'b1

// Value returned from an unoccupied location
`define CSB_UNMAPPED_RDATA       8'h00

// Write mask of power control: bit 4 is reserved
`define CSB_MASK_POWER_CONTROL   8'hEF
`define CSB_MASK_ALL             8'hFF

// Status word fields
`define CSB_SW_CARRY             7
`define CSB_SW_HALF_CARRY        6
`define CSB_SW_USER_ZERO         5
`define CSB_SW_BANK_HIGH         4
`define CSB_SW_BANK_LOW          3
`define CSB_SW_SIGNED_WRAP       2
`define CSB_SW_USER_ONE          1
`define CSB_SW_PARITY            0

// Power control fields
`define CSB_PC_BAUD_DOUBLER      7
`define CSB_PC_SERIAL_WAKE       6
`define CSB_PC_EXT0_WAKE         5
`define CSB_PC_RESERVED          4
`define CSB_PC_USER_ONE          3
`define CSB_PC_USER_ZERO         2
`define CSB_PC_POWER_DOWN        1
`define CSB_PC_DOZE              0

// Serial control read-back field
`define CSB_SPI_RATE_BIT0        0

// Bit-addressable registers have the low three address bits zero
`define CSB_BITADDR_LOW          3'h0
// Bit addresses with this bit set fall in the register space
`define CSB_BIT_SFR_SPACE        7

// Register banks: eight registers each in the lowest 32 bytes
`define CSB_BANK_REG_BITS        3

`endif

// ### testbench/csb_core_status_props.sv
// Checker for the core status register bank
`default_nettype none
module csb_core_status_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        muldiv_load,
  input wire logic [7:0]  muldiv_acc,
  input wire logic [7:0]  muldiv_helper,
  input wire logic        mem_ptr_load,
  input wire logic [15:0] mem_ptr_data,
  input wire logic        stack_push,
  input wire logic [7:0]  push_data,
  input wire logic        ram_wr,
  input wire logic [7:0]  ram_waddr,
  input wire logic [7:0]  ram_wdata,
  input wire logic [2:0]  work_reg_idx,
  input wire logic [7:0]  work_reg_addr,
  input wire logic        ss_pin,
  input wire logic [7:0]  spi_ctrl_in,
  input wire logic        serial_master_sel,
  input wire logic [7:0]  spi_ctrl_view,
  input wire logic [7:0]  accumulator,
  input wire logic [7:0]  multiply_helper,
  input wire logic [7:0]  stack_pointer,
  input wire logic [15:0] memory_pointer,
  input wire logic [7:0]  cpu_status_word,
  input wire logic [1:0]  bank_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_PUSH_INC: assert property (
    stack_push |=> stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("stack pointer not advanced by push");
  AST_PUSH_WR: assert property (
    stack_push |=> ram_wr && ram_waddr == stack_pointer && ram_wdata == $past(push_data))
    else $error("push write wrong");
  AST_RAM_PULSE: assert property (
    !stack_push |=> !ram_wr)
    else $error("ram write without push");
  AST_PARITY: assert property (
    cpu_status_word[0] == ^accumulator)
    else $error("parity bit wrong");
  AST_BANK: assert property (
    bank_sel == cpu_status_word[4:3] && work_reg_addr == {3'h0, bank_sel, work_reg_idx})
    else $error("bank lookup wrong");
  AST_UNMAPPED: assert property (
    sfr_rd && !(sfr_addr inside {8'h81, 8'h82, 8'h83, 8'h87, 8'hD0, 8'hE0, 8'hF0})
    |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read hit");
  AST_PC_RSVD: assert property (
    sfr_rd && sfr_addr == 8'h87 |=> sfr_hit && !sfr_rdata[4])
    else $error("reserved bit reads one");
  AST_MULDIV: assert property (
    muldiv_load |=> {accumulator, multiply_helper} == $past({muldiv_acc, muldiv_helper}))
    else $error("multiply result not loaded");
  AST_PTR: assert property (
    mem_ptr_load |=> memory_pointer == $past(mem_ptr_data))
    else $error("pointer word not loaded");
  AST_SS_VIEW: assert property (
    spi_ctrl_view == {spi_ctrl_in[7:1],
                      serial_master_sel ? spi_ctrl_in[0] : $past(ss_pin, 2)})
    else $error("select pin view wrong");
  COV_PUSH2: cover property (stack_push ##1 stack_push);
  COV_MULDIV: cover property (muldiv_load);
  COV_MISS: cover property (sfr_rd ##1 !sfr_hit);
endmodule // csb_core_status_props

bind csb_core_status csb_core_status_props csb_core_status_props_i (.*);
`default_nettype wire

// ### testbench/csb_core_status_test.sv
// Self-checking bench for the core status register bank
`default_nettype none
module csb_core_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, sfr_wr, sfr_rd, sfr_hit, sfr_bit_wr, sfr_bit_val, acc_load;
  logic        muldiv_load, flags_load, carry_in, half_carry_in, signed_wrap_in;
  logic        mem_ptr_load, stack_push, stack_pop, ram_wr, ss_pin, serial_master_sel;
  logic        baud_doubler, serial_wake_irq_en, ext0_wake_irq_en, power_down_en;
  logic        cpu_doze_en;
  logic [1:0]  bank_sel;
  logic [2:0]  work_reg_idx;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, acc_data, muldiv_acc;
  logic [7:0]  muldiv_helper, push_data, ram_waddr, ram_wdata, work_reg_addr;
  logic [7:0]  spi_ctrl_in, spi_ctrl_view, accumulator, multiply_helper;
  logic [7:0]  stack_pointer, cpu_status_word, d, e, a, acc_m;
  logic [15:0] mem_ptr_data, memory_pointer;
  int          num_errors, cmp_count, seed, i;
  logic [7:0]  regs [7] = '{8'h87, 8'hD0, 8'hE0, 8'hF0, 8'h81, 8'h82, 8'h83};
  logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};

  csb_core_status csb_core_status_i (.*);

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    sfr_addr = ad;
    sfr_wdata = dt;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [7:0] ad);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    tick;
  endtask
  task automatic bw(input logic [7:0] ad, input logic v);
    sfr_bit_addr = ad;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    tick;
    sfr_bit_wr = 1'b0;
    tick;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] dt);
    if (ad == 8'h87) return dt & 8'hEF;
    if (ad == 8'hD0) return {dt[7:1], ^acc_m};
    return dt;
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    seed = 16748;
    acc_m = 8'h00;
    {rst_b, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, acc_load, muldiv_load} = '0;
    {flags_load, carry_in, half_carry_in, signed_wrap_in, mem_ptr_load} = '0;
    {stack_push, stack_pop, serial_master_sel, work_reg_idx, spi_ctrl_in} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_addr, acc_data, muldiv_acc, muldiv_helper} = '0;
    {push_data, mem_ptr_data} = '0;
    ss_pin = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(regs[i]);
      chk({sfr_hit, sfr_rdata}, {1'b1, rstv[i]});
    end
    $display("reset values done");
    stack_push = 1'b1;
    push_data = 8'h5A;
    tick;
    chk({ram_wr, ram_waddr, ram_wdata}, {1'b1, 8'h08, 8'h5A});
    push_data = 8'hA5;
    tick;
    stack_push = 1'b0;
    chk({ram_wr, ram_waddr, ram_wdata}, {1'b1, 8'h09, 8'hA5});
    stack_pop = 1'b1;
    tick;
    stack_pop = 1'b0;
    chk({ram_wr, stack_pointer}, {1'b0, 8'h08});
    $display("stack done");
    for (i = 0; i < 40; i++) begin
      a = regs[$unsigned($random(seed)) % 7];
      d = $random(seed);
      if (a == 8'hE0) acc_m = d;
      wr(a, d);
      rd(a);
      chk({sfr_hit, sfr_rdata}, {1'b1, exp_rd(a, d)});
    end
    wr(8'h86, 8'hFF);
    rd(8'h86);
    chk({sfr_hit, sfr_rdata}, {1'b0, 8'h00});
    $display("byte access done");
    wr(8'h87, 8'hFF);
    chk({baud_doubler, serial_wake_irq_en, ext0_wake_irq_en}, 3'h7);
    chk({power_down_en, cpu_doze_en}, 2'h3);
    bw(8'h87, 1'b0);
    chk(baud_doubler, 1'b1);
    wr(8'h87, 8'h00);
    chk({baud_doubler, serial_wake_irq_en, ext0_wake_irq_en}, 3'h0);
    bw(8'hE5, ~acc_m[5]);
    acc_m[5] = ~acc_m[5];
    chk(accumulator, acc_m);
    for (i = 0; i < 4; i++) begin
      work_reg_idx = $random(seed);
      bw(8'hD4, i[1]);
      bw(8'hD3, i[0]);
      chk({bank_sel, work_reg_addr}, {i[1:0], 3'h0, i[1:0], work_reg_idx});
    end
    $display("power and bank done");
    for (i = 0; i < 20; i++) begin
      d = $random(seed);
      e = $random(seed);
      {muldiv_acc, muldiv_helper, acc_data, mem_ptr_data} = {d, e, ~d, e, d};
      {carry_in, half_carry_in, signed_wrap_in} = e[2:0];
      {muldiv_load, acc_load, flags_load, mem_ptr_load} = 4'hF;
      tick;
      {muldiv_load, acc_load, flags_load, mem_ptr_load} = 4'h0;
      chk({accumulator, multiply_helper}, {d, e});
      chk({cpu_status_word[7:6], cpu_status_word[2], cpu_status_word[0]}, {e[2:0], ^d});
      chk(memory_pointer, {e, d});
      tick;
    end
    rd(8'h83);
    chk(sfr_rdata, e);
    acc_data = $random(seed);
    acc_load = 1'b1;
    tick;
    acc_load = 1'b0;
    chk({accumulator, cpu_status_word[0]}, {acc_data, ^acc_data});
    $display("hardware loads done");
    spi_ctrl_in = $random(seed);
    for (i = 0; i < 4; i++) begin
      ss_pin = i[0];
      repeat (3) tick;
      chk(spi_ctrl_view, {spi_ctrl_in[7:1], i[0]});
    end
    serial_master_sel = 1'b1;
    tick;
    chk(spi_ctrl_view, spi_ctrl_in);
    $display("select view done");
    close_out;
  end
endmodule // csb_core_status_test
`default_nettype wire
